// >>> gpeio_top.sv
// General-purpose event signalling and I/O block reached through configuration function 0.
// Overview of operation
// RULE_01: Event output stays asserted while any enabled status bit is pending.
// RULE_02: Event output appears on a pin only when one is configured for events.
// RULE_03: Host reaches enable, input and output registers only through function 0.
// RULE_04: Enable bit 15 signals events on socket 0 zoomed-video control changes.
// RULE_05: Enable bit 14 signals events on socket 1 zoomed-video control changes.
// RULE_06: Enable bit 11 signals events when software changes either socket's power.
// RULE_07: Enable bit 8 signals events on programming-voltage changes to or from 12 V.
// RULE_08: Enable bits 4-0 signal input pin changes while configured as inputs.
// RULE_09: Enable bits 15,14,11,8,4-0 read back; reserved enable bits read zero.
// RULE_10: Input register bits 4-0 return the current pin levels.
// RULE_11: Bits 15-5 of the input and output registers read zero.
// RULE_12: Output bits 4-0 drive their pins only while configured as outputs.
// RULE_13: Output register reads return the last value written, not pin levels.
// RULE_14: Status bits set on events regardless of enable; writing one clears them.
// RULE_15: Input pins are synchronised and changes found from consecutive samples.
// RULE_16: Event output is the OR of enabled status bits, asserting within one clock.
`timescale 1ns/100ps
`default_nettype none
module gpeio_top (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [2:0]  cfg_function,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic        cfg_write,
  input  wire logic        cfg_read,
  input  wire logic [15:0] cfg_wdata,
  output logic      [15:0] cfg_rdata,
  output logic             cfg_rvalid,
  input  wire logic [4:0]  gpio_in,
  output logic      [4:0]  gpio_out,
  output logic      [4:0]  gpio_oe,
  input  wire logic [4:0]  pin_is_input,
  input  wire logic [4:0]  pin_is_output,
  input  wire logic        event_pin_configured,
  input  wire logic        socket0_zoomed_video_on,
  input  wire logic        socket1_zoomed_video_on,
  input  wire logic        power_state_written,
  input  wire logic        socket0_prog_12v,
  input  wire logic        socket1_prog_12v,
  output logic             event_out_n,
  output logic             event_out_oe
);
  logic [15:0] event_enable_reg;
  logic [15:0] event_status_reg;
  logic [15:0] event_status_next;
  logic [15:0] event_set;
  logic [4:0]  output_levels_reg;
  logic [4:0]  sync1_reg;
  logic [4:0]  sync2_reg;
  logic [4:0]  sample_prev_reg;
  logic        video0_prev_reg;
  logic        video1_prev_reg;
  logic [1:0]  prog_prev_reg;
  logic [4:0]  pin_changes;
  logic        func_ok;
  logic        wr_enable;
  logic        wr_status;
  logic        wr_output;

  assign func_ok   = (cfg_function == gpeio_pkg::CFG_FUNCTION); // RULE_03
  assign wr_enable = cfg_write && func_ok && (cfg_addr == gpeio_pkg::ADDR_EVENT_ENABLE);
  assign wr_status = cfg_write && func_ok && (cfg_addr == gpeio_pkg::ADDR_EVENT_STATUS);
  assign wr_output = cfg_write && func_ok && (cfg_addr == gpeio_pkg::ADDR_OUTPUT_LEVELS);

  // Two-stage synchroniser on the pins; the first stage feeds only the second.
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg       <= 5'h00;
      sync2_reg       <= 5'h00;
      sample_prev_reg <= 5'h00;
    end else begin
      sync1_reg       <= gpio_in; // RULE_15
      sync2_reg       <= sync1_reg; // RULE_15
      sample_prev_reg <= sync2_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      video0_prev_reg <= 1'b0;
      video1_prev_reg <= 1'b0;
      prog_prev_reg   <= 2'h0;
    end else begin
      video0_prev_reg <= socket0_zoomed_video_on;
      video1_prev_reg <= socket1_zoomed_video_on;
      prog_prev_reg   <= {socket1_prog_12v, socket0_prog_12v};
    end
  end

  // Event sources; the first sample after reset is compared against a reset value of zero.
  always_comb begin
    event_set = 16'h0000;
    event_set[gpeio_pkg::BIT_SOCKET0_VIDEO] = socket0_zoomed_video_on ^ video0_prev_reg; // RULE_04
    event_set[gpeio_pkg::BIT_SOCKET1_VIDEO] = socket1_zoomed_video_on ^ video1_prev_reg; // RULE_05
    event_set[gpeio_pkg::BIT_POWER_CHANGE]  = power_state_written; // RULE_06
    event_set[gpeio_pkg::BIT_PROG_VOLTAGE]  =
      |({socket1_prog_12v, socket0_prog_12v} ^ prog_prev_reg); // RULE_07
  end

  genvar gi;
  generate
    for (gi = 0; gi < gpeio_pkg::NUM_GPIO; gi++) begin : g_pin
      assign pin_changes[gi] = (sync2_reg[gi] ^ sample_prev_reg[gi]) && pin_is_input[gi]; // RULE_08 RULE_15
      assign gpio_out[gi] = output_levels_reg[gi];
      assign gpio_oe[gi]  = pin_is_output[gi]; // RULE_12
    end
  endgenerate

  // A set arriving with a write-one clear wins over the clear.
  always_comb begin
    event_status_next = event_status_reg;
    if (wr_status) begin
      event_status_next = event_status_reg & ~cfg_wdata; // RULE_14
    end
    event_status_next = (event_status_next | event_set | {11'h000, pin_changes})
                        & gpeio_pkg::EVENT_MASK; // RULE_14
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      event_status_reg <= gpeio_pkg::EVENT_STATUS_RESET;
    end else begin
      event_status_reg <= event_status_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      event_enable_reg <= gpeio_pkg::EVENT_ENABLE_RESET;
    end else if (wr_enable) begin
      event_enable_reg <= cfg_wdata & gpeio_pkg::EVENT_MASK; // RULE_09
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      output_levels_reg <= gpeio_pkg::OUTPUT_RESET;
    end else if (wr_output) begin
      output_levels_reg <= cfg_wdata[4:0]; // RULE_13
    end
  end

  // Read data is registered and appears one cycle after the read strobe.
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_rdata  <= 16'h0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_read;
      cfg_rdata  <= 16'h0000;
      if (cfg_read && func_ok) begin // RULE_03
        unique case (cfg_addr)
          gpeio_pkg::ADDR_EVENT_STATUS:  cfg_rdata <= event_status_reg;
          gpeio_pkg::ADDR_EVENT_ENABLE:  cfg_rdata <= event_enable_reg; // RULE_09
          gpeio_pkg::ADDR_INPUT_LEVELS:  cfg_rdata <= {11'h000, sync2_reg}; // RULE_10 RULE_11
          gpeio_pkg::ADDR_OUTPUT_LEVELS: cfg_rdata <= {11'h000, output_levels_reg}; // RULE_11 RULE_13
          default:                       cfg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Low while an enabled status bit is pending and a pin carries the event.
  assign event_out_n  = ~(event_pin_configured &&
                          |(event_status_reg & event_enable_reg)); // RULE_01 RULE_02 RULE_16
  assign event_out_oe = event_pin_configured; // RULE_02
endmodule : gpeio_top
`default_nettype wire

// >>> gpeio_pkg.sv
// Constants for the general-purpose event and I/O block.
package gpeio_pkg;
  localparam logic [7:0]  ADDR_EVENT_STATUS  = 8'ha8;
  localparam logic [7:0]  ADDR_EVENT_ENABLE  = 8'haa;
  localparam logic [7:0]  ADDR_INPUT_LEVELS  = 8'hac;
  localparam logic [7:0]  ADDR_OUTPUT_LEVELS = 8'hae;
  localparam logic [2:0]  CFG_FUNCTION       = 3'h0;
  localparam logic [15:0] EVENT_MASK         = 16'hc91f;
  localparam logic [15:0] LEVEL_MASK         = 16'h001f;
  localparam logic [15:0] EVENT_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] EVENT_STATUS_RESET = 16'h0000;
  localparam logic [4:0]  OUTPUT_RESET       = 5'h00;
  localparam int          BIT_SOCKET0_VIDEO  = 15;
  localparam int          BIT_SOCKET1_VIDEO  = 14;
  localparam int          BIT_POWER_CHANGE   = 11;
  localparam int          BIT_PROG_VOLTAGE   = 8;
  localparam int          NUM_GPIO           = 5;
endpackage : gpeio_pkg

// >>> gpeio_properties.sv
// Port-level checker for the general-purpose event and I/O block.
`timescale 1ns/100ps
`default_nettype none
module gpeio_properties (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        cfg_read,
  input wire logic        cfg_write,
  input wire logic        cfg_rvalid,
  input wire logic        event_pin_configured,
  input wire logic        event_out_n,
  input wire logic        event_out_oe,
  input wire logic [2:0]  cfg_function,
  input wire logic [7:0]  cfg_addr,
  input wire logic [15:0] cfg_wdata,
  input wire logic [15:0] cfg_rdata,
  input wire logic [4:0]  gpio_out,
  input wire logic [4:0]  gpio_oe,
  input wire logic [4:0]  pin_is_output
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic out_wr;
  assign out_wr = cfg_write && cfg_function == 3'h0 && cfg_addr == gpeio_pkg::ADDR_OUTPUT_LEVELS;
  a_read_answer: assert property (cfg_read |=> cfg_rvalid)
    else $error("read not answered");
  a_valid_cause: assert property (cfg_rvalid |-> $past(cfg_read))
    else $error("answer without read");
  a_other_function: assert property (cfg_read && cfg_function != 3'h0 |=> cfg_rdata == 16'h0)
    else $error("other function served");
  a_enable_reserved: assert property (cfg_read && cfg_addr == 8'haa |=> cfg_rdata[13:12] == 2'h0 && cfg_rdata[10:9] == 2'h0 && cfg_rdata[7:5] == 3'h0)
    else $error("reserved enable bit set");
  a_level_reserved: assert property (cfg_read && cfg_addr[7:2] == 6'h2b |=> cfg_rdata[15:5] == 11'h0)
    else $error("reserved level bit set");
  a_output_write: assert property (out_wr |=> gpio_out == $past(cfg_wdata[4:0]))
    else $error("output write lost");
  a_output_hold: assert property (!out_wr |=> $stable(gpio_out))
    else $error("output changed unwritten");
  a_drive_enable: assert property (gpio_oe == pin_is_output)
    else $error("output enable wrong");
  a_event_gate: assert property (!event_pin_configured |-> event_out_n && !event_out_oe)
    else $error("event shown unconfigured");
  cover property (cfg_read && cfg_function != 3'h0);
  cover property (!event_out_n);
  cover property (out_wr);
endmodule : gpeio_properties
bind gpeio_top gpeio_properties u_props (.clock(clock), .rst(rst), .cfg_read(cfg_read),
  .cfg_write(cfg_write), .cfg_rvalid(cfg_rvalid), .event_pin_configured(event_pin_configured),
  .event_out_n(event_out_n), .event_out_oe(event_out_oe), .cfg_function(cfg_function),
  .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .pin_is_output(pin_is_output));
`default_nettype wire

// >>> gpeio_board.sv
// Board pin model: a pad reads back the block's drive while enabled, else the board level.
`timescale 1ns/100ps
`default_nettype none
module gpeio_board (
  input  wire logic [4:0] ext_level,
  input  wire logic [4:0] gpio_out,
  input  wire logic [4:0] gpio_oe,
  output logic      [4:0] gpio_in
);
  assign gpio_in = (gpio_out & gpio_oe) | (ext_level & ~gpio_oe);
endmodule : gpeio_board
`default_nettype wire

// >>> gpeio_top_tb.sv
// Self-checking testbench for the general-purpose event and I/O block.
`timescale 1ns/100ps
`default_nettype none
module gpeio_top_tb;
  logic clock = 0, rst = 1, cfg_write = 0, cfg_read = 0, event_pin_configured = 1;
  logic power_state_written = 0, cfg_rvalid, event_out_n, event_out_oe;
  logic [2:0] cfg_function = 0;
  logic [7:0] cfg_addr = 0;
  logic [15:0] cfg_wdata = 0, cfg_rdata;
  logic [4:0] pin_is_input = 5'h1f, pin_is_output = 5'h1f, gpio_in, gpio_out, gpio_oe;
  logic [9:0] src = 0;
  int n_mismatch = 0, compares = 0, n;
  int bitpos [10] = '{0, 1, 2, 3, 4, 15, 14, 8, 8, 11};
  gpeio_board u_board (.ext_level(src[4:0]), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in));
  gpeio_top uut (.clock(clock), .rst(rst), .cfg_function(cfg_function), .cfg_addr(cfg_addr),
    .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pin_is_input(pin_is_input), .pin_is_output(pin_is_output), .event_out_oe(event_out_oe),
    .event_pin_configured(event_pin_configured), .socket0_zoomed_video_on(src[5]),
    .socket1_zoomed_video_on(src[6]), .power_state_written(power_state_written),
    .socket0_prog_12v(src[7]), .socket1_prog_12v(src[8]), .event_out_n(event_out_n));
  initial forever #5 clock = ~clock;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock); cfg_addr = a; cfg_wdata = d; cfg_write = 1;
    @(negedge clock); cfg_write = 0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge clock); cfg_addr = a; cfg_read = 1;
    @(negedge clock); cfg_read = 0;
    chk(cfg_rvalid ? cfg_rdata : 16'hxxxx, e);
  endtask : rd
  task t_regs;
    rd(8'haa, 16'h0);
    rd(8'hae, 16'h0);
    wr(8'haa, 16'hffff);
    rd(8'haa, 16'hc91f);
    wr(8'hae, 16'hffea);
    rd(8'hae, 16'h000a);
    chk({11'h0, gpio_in}, 16'h000a);
    cfg_function = 3'h1;
    wr(8'hae, 16'h0);
    rd(8'hae, 16'h0);
    cfg_function = 3'h0;
    rd(8'hae, 16'h000a);
    rd(8'ha0, 16'h0);
    $display("register test done");
  endtask : t_regs
  task t_events;
    pin_is_output = 0;
    repeat (4) @(negedge clock);
    wr(8'ha8, 16'hffff);
    chk({15'h0, event_out_n}, 16'h1);
    for (int i = 0; i < 10; i++) begin
      if (i == 9) begin
        power_state_written = 1;
        @(negedge clock); power_state_written = 0;
      end else src[i] = ~src[i];
      for (n = 0; n < 8 && event_out_n !== 1'b0; n++) @(negedge clock);
      chk({15'h0, event_out_n}, 16'h0);
      if (event_out_n !== 1'b0) stop_test();
      rd(8'ha8, 16'h1 << bitpos[i]);
      rd(8'hac, {11'h0, src[4:0]});
      wr(8'ha8, 16'h1 << bitpos[i]);
      chk({15'h0, event_out_n}, 16'h1);
    end
    pin_is_input = 5'h1e; src[0] = ~src[0];
    repeat (5) @(negedge clock);
    chk({15'h0, event_out_n}, 16'h1);
    wr(8'haa, 16'h0); src[5] = ~src[5];
    repeat (2) @(negedge clock);
    chk({15'h0, event_out_n}, 16'h1);
    rd(8'ha8, 16'h8000);
    wr(8'haa, 16'h8000);
    chk({15'h0, event_out_n}, 16'h0);
    event_pin_configured = 0;
    @(negedge clock);
    chk({15'h0, event_out_n}, 16'h1);
    $display("event test done");
  endtask : t_events
  task stop_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(negedge clock);
    rst = 0;
    t_regs();
    t_events();
    stop_test();
  end
endmodule : gpeio_top_tb
`default_nettype wire
